// ---- shared/pesc_pkg.sv ----
// Register map, field positions and limits of the event status block
package pesc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IDX_W  = ADDR_W - 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STAT1 = 6'h12;
  localparam logic [IDX_W-1:0] IDX_STAT2 = 6'h13;
  localparam logic [IDX_W-1:0] IDX_FCC   = 6'h14;
  localparam logic [IDX_W-1:0] IDX_REC   = 6'h15;

  // Second status register field positions
  localparam int unsigned UV_STAT_BIT  = 15;
  localparam int unsigned OV_STAT_BIT  = 14;
  localparam int unsigned OT_STAT_BIT  = 11;
  localparam int unsigned SL_STAT_BIT  = 10;
  localparam int unsigned POL_STAT_BIT = 9;
  localparam int unsigned JAB_STAT_BIT = 8;
  localparam int unsigned UV_EN_BIT    = 7;
  localparam int unsigned OV_EN_BIT    = 6;
  localparam int unsigned OT_EN_BIT    = 3;
  localparam int unsigned SL_EN_BIT    = 2;
  localparam int unsigned POL_EN_BIT   = 1;
  localparam int unsigned JAB_EN_BIT   = 0;

  // First status register field positions (half-full part only)
  localparam int unsigned FC_HF_STAT_BIT = 9;
  localparam int unsigned RX_HF_STAT_BIT = 8;
  localparam int unsigned FC_HF_EN_BIT   = 1;
  localparam int unsigned RX_HF_EN_BIT   = 0;

  // Positions inside the event latch vectors
  localparam int unsigned EV_N   = 6;
  localparam int unsigned EV_UV  = 5;
  localparam int unsigned EV_OV  = 4;
  localparam int unsigned EV_OT  = 3;
  localparam int unsigned EV_SL  = 2;
  localparam int unsigned EV_POL = 1;
  localparam int unsigned EV_JAB = 0;
  localparam int unsigned HF_N   = 2;
  localparam int unsigned HF_FC  = 1;
  localparam int unsigned HF_RX  = 0;

  // Counter widths and limits
  localparam int unsigned    FC_W    = 8;
  localparam logic [7:0]     FC_MAX  = 8'hff;
  localparam logic [7:0]     FC_HALF = 8'h7f;
  localparam int unsigned    RX_W    = 16;
  localparam logic [15:0]    RX_MAX  = 16'hffff;
  localparam logic [15:0]    RX_HALF = 16'h7fff;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ---- rtl/pesc_event_latch.sv ----
// Latched-high status bits with per-bit enables and gated interrupt
`timescale 1ns/1ps
`default_nettype none

module pesc_event_latch #(
  parameter int unsigned W = 6
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] event_in,
  input  wire logic         rd_clear,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] status,
  output logic      [W-1:0] enable,
  output logic              irq
);

  logic [W-1:0] status_reg;
  logic [W-1:0] enable_reg;

  // Set wins over the read clear, so no event is lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= '0;
    else
      status_reg <= (status_reg & ~{W{rd_clear}}) | event_in; // [RL20]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      enable_reg <= '0;
    else if (wr_en)
      enable_reg <= wr_data;
  end

  assign status = status_reg;
  assign enable = enable_reg;
  assign irq    = |(status_reg & enable_reg); // [RL21]

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_latch_hold: // [RL1] [RL6]
    assert property (!rd_clear |=> (status & $past(status)) == $past(status))
    else $error("latched status bit dropped without a read");

  a_read_clear: // [RL20]
    assert property (rd_clear |=> status == $past(event_in))
    else $error("status read did not clear idle bits");

endmodule

`default_nettype wire

// ---- rtl/pesc_sat_counter.sv ----
// Saturating clear-on-read event counter with half-full pulse
`timescale 1ns/1ps
`default_nettype none

module pesc_sat_counter #(
  parameter int unsigned    W    = 8,
  parameter logic [W-1:0]   MAX  = {W{1'b1}},
  parameter logic [W-1:0]   HALF = {1'b0, {(W-1){1'b1}}}
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         inc,
  input  wire logic         rd_clear,
  output logic      [W-1:0] count,
  output logic              half_evt
);

  logic [W-1:0] count_reg;
  logic         half_reg;

  // An event in the read cycle counts after the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= '0;
    else if (rd_clear)
      count_reg <= inc ? W'(1) : '0; // [RL13]
    else if (inc && count_reg != MAX)
      count_reg <= count_reg + W'(1); // [RL11] [RL16]
  end

  // Pulse once when the count passes the half-full mark
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      half_reg <= 1'b0;
    else
      half_reg <= inc && !rd_clear && count_reg == HALF; // [RL12] [RL17]
  end

  assign count    = count_reg;
  assign half_evt = half_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_cross;
    inc && !rd_clear && count == HALF;
  endsequence

  a_sat_hold: // [RL11] [RL16]
    assert property (inc && !rd_clear && count == MAX |=> count == MAX)
    else $error("counter moved past its maximum");

  a_half_cross: // [RL12] [RL17]
    assert property (s_cross |=> half_evt && count == HALF + W'(1))
    else $error("half-full pulse missing at crossing");

  a_half_cause: // [RL12] [RL17]
    assert property (half_evt |-> $past(count) == HALF)
    else $error("half-full pulse without crossing");

  a_read_clear: // [RL13]
    assert property (rd_clear && !inc |=> count == '0)
    else $error("counter not cleared by read");

endmodule

`default_nettype wire

// ---- rtl/pesc_top.sv ----
// Event status, enables and error counters behind an AXI4-Lite slave
// Operation
// [RL1] Undervoltage event latches status bit 15 until cleared.
// [RL2] Overvoltage event latches status bit 14 until cleared.
// [RL3] Overtemperature event latches bit 11; zero when none pending.
// [RL4] Sleep mode event latches bit 10; zero when none pending.
// [RL5] Receive polarity change latches bit 9; zero when none pending.
// [RL6] Jabber detection latches bit 8; zero when none pending.
// [RL7] Bits 7 and 6 enable undervoltage and overvoltage; reset zero.
// [RL8] Bits 3 and 2 enable overtemperature and sleep; reset zero.
// [RL9] Bits 1 and 0 enable polarity change and jabber; reset zero.
// [RL10] False-carrier counter is 8 bits in low byte; upper byte zero.
// [RL11] False-carrier counter saturates at its maximum.
// [RL12] False-carrier count passing half-full raises an event.
// [RL13] Reading a counter returns its value, then clears it.
// [RL14] Receive errors count with carrier, data valid and bad symbol.
// [RL15] Receive errors are not counted in interface loopback.
// [RL16] Receive-error counter stops at its maximum count.
// [RL17] Receive-error count passing half-full raises an event.
// [RL18] False-carrier half-full sets first-register bit 9, enable bit 1.
// [RL19] Receive-error half-full sets first-register bit 8, enable bit 0.
// [RL20] Reading status clears latched bits unless event still present.
// [RL21] Interrupt is high while any latched bit meets its enable.
`timescale 1ns/1ps
`default_nettype none

module pesc_top (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [pesc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [pesc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        undervoltage_evt,
  input  wire logic                        overvoltage_evt,
  input  wire logic                        overtemp_evt,
  input  wire logic                        sleep_mode_evt,
  input  wire logic                        polarity_change_evt,
  input  wire logic                        jabber_evt,
  input  wire logic                        false_carrier_evt,
  input  wire logic                        rx_carrier_valid,
  input  wire logic                        rx_data_valid,
  input  wire logic                        rx_invalid_symbol,
  input  wire logic                        mii_loopback_active,
  output logic                             fc_half_full_evt,
  output logic                             rx_half_full_evt,
  output logic                             irq
);

  import pesc_pkg::*;

  function automatic logic [IDX_W-1:0] idx_of(
    input logic [ADDR_W-1:0] addr
  );
    idx_of = addr[ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = (idx == IDX_STAT1) || (idx == IDX_STAT2) ||
                (idx == IDX_FCC) || (idx == IDX_REC);
  endfunction

  // Write channel state
  logic              aw_held_reg;
  logic [IDX_W-1:0]  awidx_reg;
  logic              w_held_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;

  // Read channel state
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              do_wr;
  logic [IDX_W-1:0]  widx;
  logic [IDX_W-1:0]  ridx;
  logic [31:0]       wdata_cur;
  logic [3:0]        wstrb_cur;

  logic              wr_stat1;
  logic              wr_stat2;
  logic              rd_stat1;
  logic              rd_stat2;
  logic              rd_fcc;
  logic              rd_rec;
  logic              rx_err_inc;

  logic [EV_N-1:0]   st2_event;
  logic [EV_N-1:0]   st2_status;
  logic [EV_N-1:0]   st2_enable;
  logic [EV_N-1:0]   st2_wr_bits;
  logic              st2_irq;
  logic [HF_N-1:0]   st1_event;
  logic [HF_N-1:0]   st1_status;
  logic [HF_N-1:0]   st1_enable;
  logic [HF_N-1:0]   st1_wr_bits;
  logic              st1_irq;
  logic [FC_W-1:0]   fc_count;
  logic [RX_W-1:0]   rec_count;
  logic              fc_half;
  logic              rx_half;
  logic [31:0]       rd_word;

  // Address and data may arrive in either order
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  assign widx      = aw_held_reg ? awidx_reg : idx_of(s_axi_awaddr);
  assign wdata_cur = w_held_reg ? wdata_reg : s_axi_wdata;
  assign wstrb_cur = w_held_reg ? wstrb_reg : s_axi_wstrb;
  assign do_wr     = (aw_held_reg || aw_hs) && (w_held_reg || w_hs);
  assign ridx      = idx_of(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      awidx_reg   <= '0;
    end
    else if (do_wr)
      aw_held_reg <= 1'b0;
    else if (aw_hs)
    begin
      aw_held_reg <= 1'b1;
      awidx_reg   <= idx_of(s_axi_awaddr);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end
    else if (do_wr)
      w_held_reg <= 1'b0;
    else if (w_hs)
    begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end
  end

  // Writes to read-only or unused locations are ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= is_mapped(widx) ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // Enables live in the low byte only
  assign wr_stat2 = do_wr && widx == IDX_STAT2 && wstrb_cur[0];
  assign wr_stat1 = do_wr && widx == IDX_STAT1 && wstrb_cur[0];

  assign st2_wr_bits[EV_UV]  = wdata_cur[UV_EN_BIT];  // [RL7]
  assign st2_wr_bits[EV_OV]  = wdata_cur[OV_EN_BIT];  // [RL7]
  assign st2_wr_bits[EV_OT]  = wdata_cur[OT_EN_BIT];  // [RL8]
  assign st2_wr_bits[EV_SL]  = wdata_cur[SL_EN_BIT];  // [RL8]
  assign st2_wr_bits[EV_POL] = wdata_cur[POL_EN_BIT]; // [RL9]
  assign st2_wr_bits[EV_JAB] = wdata_cur[JAB_EN_BIT]; // [RL9]
  assign st1_wr_bits[HF_FC]  = wdata_cur[FC_HF_EN_BIT]; // [RL18]
  assign st1_wr_bits[HF_RX]  = wdata_cur[RX_HF_EN_BIT]; // [RL19]

  // Read side effects happen when the address is accepted
  assign rd_stat1 = ar_hs && ridx == IDX_STAT1;
  assign rd_stat2 = ar_hs && ridx == IDX_STAT2;
  assign rd_fcc   = ar_hs && ridx == IDX_FCC;
  assign rd_rec   = ar_hs && ridx == IDX_REC;

  assign st2_event[EV_UV]  = undervoltage_evt;    // [RL1]
  assign st2_event[EV_OV]  = overvoltage_evt;     // [RL2]
  assign st2_event[EV_OT]  = overtemp_evt;        // [RL3]
  assign st2_event[EV_SL]  = sleep_mode_evt;      // [RL4]
  assign st2_event[EV_POL] = polarity_change_evt; // [RL5]
  assign st2_event[EV_JAB] = jabber_evt;          // [RL6]

  pesc_event_latch #(
    .W (EV_N)
  ) u_stat2 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .event_in (st2_event),
    .rd_clear (rd_stat2),
    .wr_en    (wr_stat2),
    .wr_data  (st2_wr_bits),
    .status   (st2_status),
    .enable   (st2_enable),
    .irq      (st2_irq)
  );

  // Loopback traffic is not line traffic, so it is never counted
  assign rx_err_inc = rx_carrier_valid && rx_data_valid &&
                      rx_invalid_symbol && !mii_loopback_active; // [RL14] [RL15]

  pesc_sat_counter #(
    .W    (FC_W),
    .MAX  (FC_MAX),
    .HALF (FC_HALF)
  ) u_fc_cnt (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .inc      (false_carrier_evt),
    .rd_clear (rd_fcc),
    .count    (fc_count),
    .half_evt (fc_half)
  );

  pesc_sat_counter #(
    .W    (RX_W),
    .MAX  (RX_MAX),
    .HALF (RX_HALF)
  ) u_rx_cnt (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .inc      (rx_err_inc),
    .rd_clear (rd_rec),
    .count    (rec_count),
    .half_evt (rx_half)
  );

  assign st1_event[HF_FC] = fc_half; // [RL18]
  assign st1_event[HF_RX] = rx_half; // [RL19]

  pesc_event_latch #(
    .W (HF_N)
  ) u_stat1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .event_in (st1_event),
    .rd_clear (rd_stat1),
    .wr_en    (wr_stat1),
    .wr_data  (st1_wr_bits),
    .status   (st1_status),
    .enable   (st1_enable),
    .irq      (st1_irq)
  );

  assign fc_half_full_evt = fc_half;
  assign rx_half_full_evt = rx_half;
  assign irq              = st2_irq || st1_irq; // [RL21]

  // Reserved bits read as zero
  always_comb
  begin
    rd_word = '0;
    case (ridx)
      IDX_STAT1:
      begin
        rd_word[FC_HF_STAT_BIT] = st1_status[HF_FC];
        rd_word[RX_HF_STAT_BIT] = st1_status[HF_RX];
        rd_word[FC_HF_EN_BIT]   = st1_enable[HF_FC];
        rd_word[RX_HF_EN_BIT]   = st1_enable[HF_RX];
      end
      IDX_STAT2:
      begin
        rd_word[UV_STAT_BIT]  = st2_status[EV_UV];  // [RL1]
        rd_word[OV_STAT_BIT]  = st2_status[EV_OV];  // [RL2]
        rd_word[OT_STAT_BIT]  = st2_status[EV_OT];  // [RL3]
        rd_word[SL_STAT_BIT]  = st2_status[EV_SL];  // [RL4]
        rd_word[POL_STAT_BIT] = st2_status[EV_POL]; // [RL5]
        rd_word[JAB_STAT_BIT] = st2_status[EV_JAB]; // [RL6]
        rd_word[UV_EN_BIT]    = st2_enable[EV_UV];
        rd_word[OV_EN_BIT]    = st2_enable[EV_OV];
        rd_word[OT_EN_BIT]    = st2_enable[EV_OT];
        rd_word[SL_EN_BIT]    = st2_enable[EV_SL];
        rd_word[POL_EN_BIT]   = st2_enable[EV_POL];
        rd_word[JAB_EN_BIT]   = st2_enable[EV_JAB];
      end
      IDX_FCC:
        rd_word[FC_W-1:0] = fc_count; // [RL10]
      IDX_REC:
        rd_word[RX_W-1:0] = rec_count; // [RL13]
      default:
        rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= is_mapped(ridx) ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_fc_read;
    ar_hs && ridx == IDX_FCC;
  endsequence

  sequence s_rec_read;
    ar_hs && ridx == IDX_REC;
  endsequence

  a_uv_latch: // [RL1]
    assert property (undervoltage_evt |=> st2_status[EV_UV])
    else $error("undervoltage status not latched");

  a_ov_latch: // [RL2]
    assert property (overvoltage_evt |=> st2_status[EV_OV])
    else $error("overvoltage status not latched");

  a_ot_latch: // [RL3]
    assert property (overtemp_evt |=> st2_status[EV_OT])
    else $error("overtemperature status not latched");

  a_sleep_latch: // [RL4]
    assert property (sleep_mode_evt |=> st2_status[EV_SL])
    else $error("sleep status not latched");

  a_pol_latch: // [RL5]
    assert property (polarity_change_evt |=> st2_status[EV_POL])
    else $error("polarity status not latched");

  a_jab_latch: // [RL6]
    assert property (jabber_evt |=> st2_status[EV_JAB])
    else $error("jabber status not latched");

  a_enable_write: // [RL7] [RL8] [RL9]
    assert property (wr_stat2 |=> st2_enable == $past(st2_wr_bits))
    else $error("enable bits not taken from write");

  a_fc_read_value: // [RL10] [RL13]
    assert property (s_fc_read ##1 s_axi_rvalid |->
      s_axi_rdata == {24'h000000, $past(fc_count)})
    else $error("false-carrier read value wrong");

  a_rec_read_value: // [RL13]
    assert property (s_rec_read |=>
      s_axi_rvalid && s_axi_rdata[RX_W-1:0] == $past(rec_count))
    else $error("receive-error read value wrong");

  a_rxerr_gate: // [RL14] [RL15]
    assert property (!rx_err_inc && !rd_rec |=> $stable(rec_count))
    else $error("receive-error counter moved without cause");

  a_rxerr_loop: // [RL15]
    assert property (mii_loopback_active && !rd_rec |=>
      $stable(rec_count))
    else $error("receive error counted in loopback");

  a_rxerr_count: // [RL14]
    assert property (rx_err_inc && !rd_rec && rec_count != RX_MAX |=>
      rec_count == $past(rec_count) + 16'h0001)
    else $error("receive error not counted");

  a_fc_hf_stat: // [RL18]
    assert property (fc_half ##1 !rd_stat1 |=> st1_status[HF_FC])
    else $error("false-carrier half-full not latched");

  a_rx_hf_stat: // [RL19]
    assert property (rx_half |=> st1_status[HF_RX])
    else $error("receive-error half-full not latched");

  a_stat_clear: // [RL20]
    assert property (rd_stat2 && !(|st2_event) |=> st2_status == '0)
    else $error("status read did not clear bits");

  a_irq_level: // [RL21]
    assert property ((|(st2_status & st2_enable)) ||
      (|(st1_status & st1_enable)) |-> irq)
    else $error("interrupt low with enabled pending bit");

  a_axi_read: // [RL13]
    assert property (ar_hs |=> s_axi_rvalid [*1] ##0 !s_axi_arready)
    else $error("read answer not given next cycle");

endmodule

`default_nettype wire

// ---- test/pesc_host.sv ----
// Management host model issuing single AXI4-Lite transfers
`timescale 1ns/1ps
`default_nettype none

module pesc_host (
  input  wire logic                        aclk,
  output var  logic [pesc_pkg::ADDR_W-1:0] s_axi_awaddr,
  output var  logic                        s_axi_awvalid,
  input  wire logic                        s_axi_awready,
  output var  logic [31:0]                 s_axi_wdata,
  output var  logic [3:0]                  s_axi_wstrb,
  output var  logic                        s_axi_wvalid,
  input  wire logic                        s_axi_wready,
  input  wire logic [1:0]                  s_axi_bresp,
  input  wire logic                        s_axi_bvalid,
  output var  logic                        s_axi_bready,
  output var  logic [pesc_pkg::ADDR_W-1:0] s_axi_araddr,
  output var  logic                        s_axi_arvalid,
  input  wire logic                        s_axi_arready,
  input  wire logic [31:0]                 s_axi_rdata,
  input  wire logic [1:0]                  s_axi_rresp,
  input  wire logic                        s_axi_rvalid,
  output var  logic                        s_axi_rready
);
  import pesc_pkg::*;

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end

  // Address and data may be taken at different edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (!aw && s_axi_awready)
      begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready)
      begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- test/phy_event_status_and_error_counters_tb.sv ----
// Self-checking bench for the event status and counter block
`timescale 1ns/1ps
`default_nettype none

module phy_event_status_and_error_counters_tb;
  import pesc_pkg::*;

  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, fc_half_full_evt, rx_half_full_evt, irq;
  logic              aclk = 0;
  logic              aresetn = 0;
  // Bits: 5..0 events, 6 false carrier, 7..9 rx, 10 loopback
  logic [10:0]       stim = '0;
  int                n_mismatch = 0, checked = 0, cyc = 0, nfc = 0, nrx = 0;
  int                pos[6] = '{8, 9, 10, 11, 14, 15};
  logic [10:0]       nog[4] = '{11'h780, 11'h180, 11'h280, 11'h300};

  pesc_host host_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  pesc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .undervoltage_evt(stim[5]), .overvoltage_evt(stim[4]),
    .overtemp_evt(stim[3]), .sleep_mode_evt(stim[2]),
    .polarity_change_evt(stim[1]), .jabber_evt(stim[0]),
    .false_carrier_evt(stim[6]), .rx_carrier_valid(stim[7]),
    .rx_data_valid(stim[8]), .rx_invalid_symbol(stim[9]),
    .mii_loopback_active(stim[10]), .fc_half_full_evt, .rx_half_full_evt,
    .irq);

  always #5 aclk = ~aclk;

  task summarize();
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Holds a stimulus pattern for n sampled edges
  task hold(input logic [10:0] v, input int n);
    @(posedge aclk);
    stim <= v;
    repeat (n) @(posedge aclk);
    stim <= '0;
  endtask

  // Ceiling well above the longest counter fill
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (fc_half_full_evt === 1'b1)
      nfc <= nfc + 1;
    if (rx_half_full_evt === 1'b1)
      nrx <= nrx + 1;
    if (cyc == 90000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    host_u.rd(8'h4c, d, r);
    chk(d, 32'h0);
    host_u.wr(8'h50, 32'hff, r);
    chk(32'(r), 32'(RESP_OKAY));
    host_u.rd(8'h50, d, r);
    chk(d, 32'h0);
    host_u.rd(8'h00, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(RESP_DECERR));
    host_u.wr(8'h4c, 32'hffff, r);
    host_u.rd(8'h4c, d, r);
    chk(d, 32'hcf);
    for (int i = 0; i < 6; i++)
    begin
      hold(11'h1 << i, 1);
      #1 chk(32'(irq), 32'h1);
      host_u.rd(8'h4c, d, r);
      chk(d, 32'hcf | (32'h1 << pos[i]));
      host_u.rd(8'h4c, d, r);
      chk(d, 32'hcf);
      chk(32'(irq), 32'h0);
    end
    host_u.wr(8'h48, 32'h3, r);
    hold(11'h040, 128);
    repeat (3) @(posedge aclk);
    #1 chk(32'(nfc), 32'h1);
    chk(32'(irq), 32'h1);
    host_u.rd(8'h48, d, r);
    chk(d, 32'h203);
    host_u.rd(8'h50, d, r);
    chk(d, 32'h80);
    host_u.rd(8'h50, d, r);
    chk(d, 32'h0);
    hold(11'h040, 300);
    host_u.rd(8'h50, d, r);
    chk(d, 32'hff);
    chk(32'(nfc), 32'h2);
    foreach (nog[k])
      hold(nog[k], 10);
    host_u.rd(8'h54, d, r);
    chk(d, 32'h0);
    hold(11'h380, 32768);
    repeat (3) @(posedge aclk);
    #1 chk(32'(nrx), 32'h1);
    host_u.rd(8'h48, d, r);
    chk(d, 32'h303);
    host_u.rd(8'h48, d, r);
    chk(d, 32'h3);
    hold(11'h380, 32771);
    host_u.rd(8'h54, d, r);
    chk(d, 32'hffff);
    host_u.rd(8'h54, d, r);
    chk(d, 32'h0);
    chk(32'(nrx), 32'h1);
    summarize();
  end
endmodule

`default_nettype wire
